// ---- rtl/csr_consts.svh ----
// offsets, field positions, reset values and timing counts of the charger register bank
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH
`define CSR_ADDR_CTRL1 4'h5
`define CSR_ADDR_CTRL2 4'h6
`define CSR_ADDR_INT_STAT 4'h7
`define CSR_ADDR_FLT_STAT 4'h8
`define CSR_ADDR_INT_FLAG 4'h9
`define CSR_ADDR_FLT_FLAG 4'ha
`define CSR_ADDR_INT_MASK 4'hb
`define CSR_ADDR_FLT_MASK 4'hc
`define CSR_ADDR_PART 4'hd
`define CSR_CTRL1_RESET 8'h9d
`define CSR_CTRL2_RESET 8'h33
`define CSR_MASK_RESET 8'h00
`define CSR_FLAG_RESET 8'h00
`define CSR_CTRL2_WMASK 8'h3b
`define CSR_CTRL2_WD_KEEP 8'h03
`define CSR_INT_MASK_WMASK 8'hfd
`define CSR_FLT_MASK_WMASK 8'hfe
`define CSR_C1_KICK 6
`define CSR_C1_WD_HI 5
`define CSR_C1_WD_LO 4
`define CSR_C1_TMR_EN 3
`define CSR_C1_SEL_HI 2
`define CSR_C1_SEL_LO 1
`define CSR_C1_SLOW 0
`define CSR_C1_TERM 7
`define CSR_C2_CHG_EN 3
`define CSR_PART_REGRST 7
// part number and revision values are arbitrary
`define CSR_PART_NUMBER 4'h5
`define CSR_PART_REV 3'h1
`define CSR_CLK_FREQ_HZ 25000000
`define CSR_CLK_MHZ 25
`define CSR_SEC_PER_HOUR 3600
`define CSR_SAFETY_H0 5
`define CSR_SAFETY_H1 8
`define CSR_SAFETY_H2 12
`define CSR_SAFETY_H3 20
`define CSR_WD_S1 40
`define CSR_WD_S2 80
`define CSR_WD_S3 160
`define CSR_POOR_SRC_TRIES 7
`define CSR_IRQ_PULSE_US 100
`endif

// ---- rtl/csr_pkg.sv ----
// types shared by the charger register bank and its users
package csr_pkg;
	typedef struct packed {
		logic powerGood;
		logic inCurReg;
		logic inVoltReg;
		logic thermReg;
		logic termination;
		logic [2:0] chargeState;
		logic ovIn;
		logic tShut;
		logic batOv;
		logic flyCap;
		logic capPre;
		logic srcQualDone;
		logic srcQualPass;
	} csr_status_in_type;
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [3:0] addr;
		logic [7:0] wrData;
	} csr_reg_req_type;
	typedef struct packed {
		logic ack;
		logic [7:0] rdData;
	} csr_reg_rsp_type;
	typedef struct packed {
		logic chargeEnable;
		logic termEnable;
		logic [1:0] thermThreshold;
		logic [1:0] lowBattThreshold;
		logic safetyExpired;
		logic wdExpired;
		logic irqPulse;
	} csr_ctrl_out_type;
	typedef enum logic [2:0] {
		WD_OFF = 3'b001,
		WD_RUN = 3'b010,
		WD_EXPIRED = 3'b100
	} csr_wd_state_type;
endpackage : csr_pkg

// ---- rtl/csr_charger_regs.sv ----
// charger control, status, event flag and mask register bank
//
// What this block does
// (R1) safety timer runs only when enabled
// (R2) timeout code selects 5/8/12/20 hours
// (R3) slowdown halves timer rate during regulation
// (R4) watchdog expiry holds charge enable cleared
// (R5) thermal threshold code, defaults to 3
// (R6) low-battery threshold survives watchdog expiry
// (R7) control two resets 33h, reserved read 0
// (R8) charge enable cleared by both resets
// (R9) live interrupt status bit layout
// (R10) three-bit charge state passed through
// (R11) live fault status bit layout
// (R12) poor source after seven failed attempts
// (R13) expiry holds four fault status bits cleared
// (R14) interrupt flags clear on read
// (R15) fault flags clear on read
// (R16) power good both edges, regulation rising
// (R17) watchdog and termination flags on rising
// (R18) charge state change sets flag
// (R19) fault flags latch on rising edges
// (R20) flags kept across watchdog expiry
// (R21) mask one suppresses interrupt pulse
// (R22) timer fault pulse only when unmasked
// (R23) kick restarts watchdog, reads zero
// (R24) watchdog code selects off/40/80/160 s
// (R25) register reset restores defaults, self clears
// (R26) unmasked new flag fires fixed pulse
// (R27) event wins over read clear
`include "csr_consts.svh"
module csr_charger_regs #(
	parameter int TICK_CYCLES = `CSR_CLK_FREQ_HZ
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire csr_pkg::csr_status_in_type statusIn,
	input wire csr_pkg::csr_reg_req_type regReq,
	output csr_pkg::csr_reg_rsp_type regRsp,
	output csr_pkg::csr_ctrl_out_type ctrlOut
);
	import csr_pkg::*;

	localparam int IRQ_CYCLES = `CSR_IRQ_PULSE_US * `CSR_CLK_MHZ;
	localparam logic [7:0] CTRL1_DEFAULT = `CSR_CTRL1_RESET;

	function automatic logic wrHit(input csr_reg_req_type req, input logic [3:0] addr);
		wrHit = req.wrEn && (req.addr == addr);
	endfunction : wrHit

	function automatic logic isMapped(input logic [3:0] addr);
		isMapped = (addr >= `CSR_ADDR_CTRL1) && (addr <= `CSR_ADDR_PART);
	endfunction : isMapped

	function automatic logic [16:0] safetyLimit(input logic [1:0] sel);
		case (sel)
			2'h0: safetyLimit = 17'(`CSR_SAFETY_H0 * `CSR_SEC_PER_HOUR);
			2'h1: safetyLimit = 17'(`CSR_SAFETY_H1 * `CSR_SEC_PER_HOUR);
			2'h2: safetyLimit = 17'(`CSR_SAFETY_H2 * `CSR_SEC_PER_HOUR);
			default: safetyLimit = 17'(`CSR_SAFETY_H3 * `CSR_SEC_PER_HOUR);
		endcase
	endfunction : safetyLimit

	function automatic logic [7:0] wdLimit(input logic [1:0] code);
		case (code)
			2'h1: wdLimit = 8'(`CSR_WD_S1);
			2'h2: wdLimit = 8'(`CSR_WD_S2);
			default: wdLimit = 8'(`CSR_WD_S3);
		endcase
	endfunction : wdLimit

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and second tick

	csr_status_in_type syncOne_reg;
	csr_status_in_type syncTwo_reg;
	logic [31:0] tickCnt_reg;
	logic tick;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			syncOne_reg <= '0;
			syncTwo_reg <= '0;
		end else begin
			syncOne_reg <= statusIn;
			syncTwo_reg <= syncOne_reg;
		end
	end

	assign tick = (tickCnt_reg == 32'(TICK_CYCLES - 1));

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_reg <= '0;
		end else if (tick) begin
			tickCnt_reg <= '0;
		end else begin
			tickCnt_reg <= tickCnt_reg + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers, register reset and watchdog

	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic [7:0] intMask_reg;
	logic [7:0] fltMask_reg;
	logic regReset_reg;
	csr_wd_state_type wdState_reg;
	logic [7:0] wdCnt_reg;
	logic wrCtrl1;
	logic [1:0] wdField_next;
	logic wdRestart;
	logic wdExpireNow;
	logic wdExpired;

	assign wrCtrl1 = wrHit(regReq, `CSR_ADDR_CTRL1);
	assign wdField_next = regReset_reg ? CTRL1_DEFAULT[`CSR_C1_WD_HI:`CSR_C1_WD_LO] :
		wrCtrl1 ? regReq.wrData[`CSR_C1_WD_HI:`CSR_C1_WD_LO] :
		ctrl1_reg[`CSR_C1_WD_HI:`CSR_C1_WD_LO];
	assign wdRestart = regReset_reg || (wrCtrl1 && regReq.wrData[`CSR_C1_KICK]) ||
		(wdField_next != ctrl1_reg[`CSR_C1_WD_HI:`CSR_C1_WD_LO]); // see (R23) see (R24)
	assign wdExpireNow = (wdState_reg == WD_RUN) && !wdRestart && tick &&
		((wdCnt_reg + 8'h1) >= wdLimit(ctrl1_reg[`CSR_C1_WD_HI:`CSR_C1_WD_LO]));
	assign wdExpired = (wdState_reg == WD_EXPIRED);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regReset_reg <= 1'b0;
		end else begin
			regReset_reg <= wrHit(regReq, `CSR_ADDR_PART) && regReq.wrData[`CSR_PART_REGRST]; // see (R25)
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wdState_reg <= WD_RUN;
			wdCnt_reg <= '0;
		end else if (wdRestart) begin
			wdCnt_reg <= '0;
			wdState_reg <= (wdField_next == 2'h0) ? WD_OFF : WD_RUN; // see (R24)
		end else begin
			case (wdState_reg)
				WD_RUN: begin
					if (wdExpireNow) begin
						wdState_reg <= WD_EXPIRED;
						wdCnt_reg <= '0;
					end else if (tick) begin
						wdCnt_reg <= wdCnt_reg + 8'h1;
					end
				end
				WD_OFF, WD_EXPIRED: wdCnt_reg <= '0;
				default: begin
					wdState_reg <= WD_OFF;
					wdCnt_reg <= '0;
				end
			endcase
		end
	end

	// kick is never stored, so it always reads back as zero
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl1_reg <= `CSR_CTRL1_RESET;
		end else if (regReset_reg || wdExpireNow) begin
			ctrl1_reg <= `CSR_CTRL1_RESET; // see (R25)
		end else if (wrCtrl1) begin
			ctrl1_reg <= regReq.wrData & ~(8'h1 << `CSR_C1_KICK); // see (R23)
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrl2_reg <= `CSR_CTRL2_RESET; // see (R5) see (R7)
		end else if (regReset_reg) begin
			ctrl2_reg <= `CSR_CTRL2_RESET; // see (R6) see (R8)
		end else if (wdExpireNow) begin
			ctrl2_reg <= (`CSR_CTRL2_RESET & ~`CSR_CTRL2_WD_KEEP) |
				(ctrl2_reg & `CSR_CTRL2_WD_KEEP); // see (R6) see (R8)
		end else if (wrHit(regReq, `CSR_ADDR_CTRL2)) begin
			ctrl2_reg <= regReq.wrData & `CSR_CTRL2_WMASK &
				~(8'(wdExpired) << `CSR_C2_CHG_EN); // see (R4) see (R7)
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			intMask_reg <= `CSR_MASK_RESET;
			fltMask_reg <= `CSR_MASK_RESET;
		end else if (regReset_reg) begin
			intMask_reg <= `CSR_MASK_RESET; // see (R21)
			fltMask_reg <= `CSR_MASK_RESET;
		end else begin
			if (wrHit(regReq, `CSR_ADDR_INT_MASK)) begin
				intMask_reg <= regReq.wrData & `CSR_INT_MASK_WMASK;
			end
			if (wrHit(regReq, `CSR_ADDR_FLT_MASK)) begin
				fltMask_reg <= regReq.wrData & `CSR_FLT_MASK_WMASK;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// safety timer

	logic [16:0] safetyCnt_reg;
	logic safetyExpired_reg;
	logic halfPhase_reg;
	logic safetyRestart;
	logic safetyStep;

	assign safetyRestart = regReset_reg || !ctrl1_reg[`CSR_C1_TMR_EN] ||
		!ctrl2_reg[`CSR_C2_CHG_EN] || (wrCtrl1 &&
		(regReq.wrData[`CSR_C1_SEL_HI:`CSR_C1_SEL_LO] !=
		ctrl1_reg[`CSR_C1_SEL_HI:`CSR_C1_SEL_LO])); // see (R1) see (R25)
	assign safetyStep = tick && (!ctrl1_reg[`CSR_C1_SLOW] || halfPhase_reg ||
		!(syncTwo_reg.inCurReg || syncTwo_reg.inVoltReg || syncTwo_reg.thermReg)); // see (R3)

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			safetyCnt_reg <= '0;
			safetyExpired_reg <= 1'b0;
			halfPhase_reg <= 1'b0;
		end else if (safetyRestart) begin
			safetyCnt_reg <= '0;
			safetyExpired_reg <= 1'b0;
			halfPhase_reg <= 1'b0;
		end else begin
			if (tick) begin
				halfPhase_reg <= !halfPhase_reg;
			end
			if (safetyStep && !safetyExpired_reg) begin
				if ((safetyCnt_reg + 17'h1) >= safetyLimit(ctrl1_reg[`CSR_C1_SEL_HI:`CSR_C1_SEL_LO])) begin
					safetyExpired_reg <= 1'b1; // see (R2)
				end
				safetyCnt_reg <= safetyCnt_reg + 17'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// poor source qualification

	logic [2:0] poorCnt_reg;
	logic poorSrc_reg;
	logic qualDonePrev_reg;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			poorCnt_reg <= '0;
			poorSrc_reg <= 1'b0;
			qualDonePrev_reg <= 1'b0;
		end else begin
			qualDonePrev_reg <= syncTwo_reg.srcQualDone;
			if (syncTwo_reg.srcQualDone && !qualDonePrev_reg) begin
				if (syncTwo_reg.srcQualPass) begin
					poorCnt_reg <= '0;
					poorSrc_reg <= 1'b0;
				end else if (poorCnt_reg == 3'(`CSR_POOR_SRC_TRIES - 1)) begin
					poorSrc_reg <= 1'b1; // see (R12)
				end else begin
					poorCnt_reg <= poorCnt_reg + 3'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// live status, event flags and interrupt pulse

	logic [7:0] intStatus;
	logic [7:0] fltStatus;
	logic [7:0] intStatPrev_reg;
	logic [7:0] fltStatPrev_reg;
	logic [1:0] miscPrev_reg;
	logic [7:0] intSet;
	logic [7:0] fltSet;
	logic [7:0] intFlag_reg;
	logic [7:0] fltFlag_reg;
	logic [7:0] intFlag_next;
	logic [7:0] fltFlag_next;
	logic rdInt;
	logic rdFlt;
	logic irqFire;
	logic [11:0] irqCnt_reg;
	logic irq_reg;

	assign intStatus = {syncTwo_reg.powerGood, syncTwo_reg.inCurReg, syncTwo_reg.inVoltReg,
		syncTwo_reg.thermReg, wdExpired, syncTwo_reg.chargeState}; // see (R9) see (R10)
	assign fltStatus = {{syncTwo_reg.ovIn, syncTwo_reg.tShut, syncTwo_reg.batOv,
		syncTwo_reg.flyCap} & ~{4{wdExpired}}, 1'b0, syncTwo_reg.capPre,
		poorSrc_reg, 1'b0}; // see (R11) see (R13)

	assign intSet = {intStatus[7] ^ intStatPrev_reg[7],
		intStatus[6:3] & ~intStatPrev_reg[6:3],
		syncTwo_reg.termination & ~miscPrev_reg[0], 1'b0,
		intStatus[2:0] != intStatPrev_reg[2:0]}; // see (R16) see (R17) see (R18)
	assign fltSet = {fltStatus[7:4] & ~fltStatPrev_reg[7:4],
		safetyExpired_reg & ~miscPrev_reg[1],
		fltStatus[2:1] & ~fltStatPrev_reg[2:1], 1'b0}; // see (R19)

	assign rdInt = regReq.rdEn && (regReq.addr == `CSR_ADDR_INT_FLAG);
	assign rdFlt = regReq.rdEn && (regReq.addr == `CSR_ADDR_FLT_FLAG);
	assign intFlag_next = (intFlag_reg & ~{8{rdInt}}) | intSet; // see (R14) see (R27)
	assign fltFlag_next = (fltFlag_reg & ~{8{rdFlt}}) | fltSet; // see (R15) see (R27)
	assign irqFire = !regReset_reg && (|(intFlag_next & ~intFlag_reg & ~intMask_reg) ||
		|(fltFlag_next & ~fltFlag_reg & ~fltMask_reg)); // see (R21) see (R22) see (R26)

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			intStatPrev_reg <= '0;
			fltStatPrev_reg <= '0;
			miscPrev_reg <= '0;
		end else begin
			intStatPrev_reg <= intStatus;
			fltStatPrev_reg <= fltStatus;
			miscPrev_reg <= {safetyExpired_reg, syncTwo_reg.termination};
		end
	end

	// watchdog expiry leaves the flags alone
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			intFlag_reg <= `CSR_FLAG_RESET;
			fltFlag_reg <= `CSR_FLAG_RESET;
		end else if (regReset_reg) begin
			intFlag_reg <= `CSR_FLAG_RESET; // see (R20)
			fltFlag_reg <= `CSR_FLAG_RESET;
		end else begin
			intFlag_reg <= intFlag_next;
			fltFlag_reg <= fltFlag_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irqCnt_reg <= '0;
			irq_reg <= 1'b0;
		end else if (irqFire) begin
			irqCnt_reg <= 12'(IRQ_CYCLES - 1); // see (R26)
			irq_reg <= 1'b1;
		end else if (irqCnt_reg != 12'h0) begin
			irqCnt_reg <= irqCnt_reg - 12'h1;
		end else begin
			irq_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read port and outputs

	logic [7:0] readMux;

	always_comb begin
		case (regReq.addr)
			`CSR_ADDR_CTRL1: readMux = ctrl1_reg;
			`CSR_ADDR_CTRL2: readMux = ctrl2_reg & `CSR_CTRL2_WMASK; // see (R7)
			`CSR_ADDR_INT_STAT: readMux = intStatus;
			`CSR_ADDR_FLT_STAT: readMux = fltStatus;
			`CSR_ADDR_INT_FLAG: readMux = intFlag_reg;
			`CSR_ADDR_FLT_FLAG: readMux = fltFlag_reg;
			`CSR_ADDR_INT_MASK: readMux = intMask_reg;
			`CSR_ADDR_FLT_MASK: readMux = fltMask_reg;
			`CSR_ADDR_PART: readMux = {1'b0, `CSR_PART_NUMBER, `CSR_PART_REV};
			default: readMux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			regRsp <= '0;
		end else begin
			regRsp.ack <= (regReq.rdEn || regReq.wrEn) && isMapped(regReq.addr);
			if (regReq.rdEn) begin
				regRsp.rdData <= isMapped(regReq.addr) ? readMux : 8'h00;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ctrlOut <= '0;
		end else begin
			ctrlOut.chargeEnable <= ctrl2_reg[`CSR_C2_CHG_EN]; // see (R8)
			ctrlOut.termEnable <= ctrl1_reg[`CSR_C1_TERM];
			ctrlOut.thermThreshold <= ctrl2_reg[5:4];
			ctrlOut.lowBattThreshold <= ctrl2_reg[1:0];
			ctrlOut.safetyExpired <= safetyExpired_reg;
			ctrlOut.wdExpired <= wdExpired;
			ctrlOut.irqPulse <= irq_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence kickWrite;
		wrCtrl1 && regReq.wrData[`CSR_C1_KICK];
	endsequence

	sequence expiredKicked;
		wdExpired ##0 kickWrite;
	endsequence

	rsvd_zero_a: assert property (regReq.rdEn && regReq.addr == `CSR_ADDR_CTRL2 |=> // see (R7)
		regRsp.rdData[7:6] == 2'h0 && !regRsp.rdData[2])
		else $error("reserved control bits read nonzero");
	int_clear_a: assert property (rdInt && intSet == 8'h0 && !regReset_reg |=> // see (R14)
		intFlag_reg == 8'h0)
		else $error("interrupt flags not cleared by read");
	flt_clear_a: assert property (rdFlt && fltSet == 8'h0 && !regReset_reg |=> // see (R15)
		fltFlag_reg == 8'h0)
		else $error("fault flags not cleared by read");
	set_wins_a: assert property (rdInt && intSet != 8'h0 && !regReset_reg |=> // see (R27)
		(intFlag_reg & $past(intSet)) == $past(intSet))
		else $error("event lost against read clear");
	chg_hold_a: assert property (wdExpired |-> !ctrl2_reg[`CSR_C2_CHG_EN]) // see (R4)
		else $error("charge enable set while watchdog expired");
	fault_hold_a: assert property (wdExpired |-> fltStatus[7:4] == 4'h0) // see (R13)
		else $error("fault status not held during expiry");
	kick_clear_a: assert property (expiredKicked |=> !wdExpired ##1 !ctrl1_reg[`CSR_C1_KICK]) // see (R23)
		else $error("kick did not end expiry");
	irq_start_a: assert property (irqFire |=> irq_reg && irqCnt_reg == 12'(IRQ_CYCLES - 1)) // see (R26)
		else $error("interrupt pulse not started");
	safety_timeout_irq_block_a: assert property ($rose(safetyExpired_reg) && fltMask_reg[3] && // see (R22)
		intSet == 8'h0 && fltSet == 8'h08 |-> !irqFire)
		else $error("masked timer fault fired interrupt");
	timer_off_a: assert property (!ctrl1_reg[`CSR_C1_TMR_EN] |=> safetyCnt_reg == 17'h0) // see (R1)
		else $error("safety timer ran while disabled");
	poor_src_a: assert property ($rose(poorSrc_reg) |-> // see (R12)
		$past(poorCnt_reg) == 3'(`CSR_POOR_SRC_TRIES - 1))
		else $error("poor source set too early");
endmodule : csr_charger_regs

// ---- verification/csr_host_model.sv ----
// host-side model that issues single-byte register requests
module csr_host_model (
	input wire logic clk_sys,
	output csr_pkg::csr_reg_req_type regReq,
	input wire csr_pkg::csr_reg_rsp_type regRsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import csr_pkg::*;
	initial regReq = '0;
	// request pulse spans one sampling edge, answer taken while ack stands
	task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
		output logic ackOut, output logic [7:0] dataOut);
		@(negedge clk_sys);
		regReq.wrEn = wr;
		regReq.rdEn = ~wr;
		regReq.addr = a;
		regReq.wrData = wr ? d : 8'h00;
		@(negedge clk_sys);
		ackOut = regRsp.ack;
		dataOut = regRsp.rdData;
		regReq = '0;
		@(negedge clk_sys);
	endtask : access
endmodule : csr_host_model

// ---- verification/tb_top.sv ----
// self-checking testbench of the charger register bank
`include "csr_consts.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import csr_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	csr_status_in_type statusIn = '0;
	csr_reg_req_type regReq;
	csr_reg_rsp_type regRsp;
	csr_ctrl_out_type ctrlOut;
	int fail_count = 0;
	int checked = 0;
	int i;
	logic ackV;
	logic seenIrq;
	logic [7:0] dataV;
	always #20 clk_sys = ~clk_sys;
	csr_charger_regs #(.TICK_CYCLES(1)) dut_u (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.statusIn(statusIn),
		.regReq(regReq),
		.regRsp(regRsp),
		.ctrlOut(ctrlOut)
	);
	csr_host_model host_u (
		.clk_sys(clk_sys),
		.regReq(regReq),
		.regRsp(regRsp)
	);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check8(input logic [7:0] exp, input logic [7:0] act);
		checked++;
		if (act !== exp) begin
			fail_count++;
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, act);
		end
	endtask : check8
	task automatic check1(input logic exp, input logic act);
		checked++;
		if (act !== exp) begin
			fail_count++;
			$display("FAIL t=%0t exp=%h got=%h", $time, exp, act);
		end
	endtask : check1
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host_u.access(1'b1, a, d, ackV, dataV);
		check1(1'b1, ackV);
	endtask : wr
	task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
		host_u.access(1'b0, a, 8'h00, ackV, dataV);
		check1(1'b1, ackV);
		check8(exp, dataV);
	endtask : rdChk
	task automatic settle;
		repeat (6) @(negedge clk_sys);
	endtask : settle
	// samples the interrupt output over a span
	task automatic watchIrq(input int n);
		seenIrq = 1'b0;
		repeat (n) begin
			@(negedge clk_sys);
			seenIrq = seenIrq | ctrlOut.irqPulse;
		end
	endtask : watchIrq
	task automatic finish_test;
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (80000) @(posedge clk_sys);
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (20) @(negedge clk_sys);
		rst_b = 1'b1;
		rdChk(`CSR_ADDR_CTRL1, 8'h9d);
		// watchdog and safety timer off early, 40 ticks are short here
		wr(`CSR_ADDR_CTRL1, 8'h01);
		rdChk(`CSR_ADDR_CTRL2, 8'h33);
		check8(8'h03, {6'h00, ctrlOut.thermThreshold});
		rdChk(`CSR_ADDR_INT_MASK, 8'h00);
		rdChk(`CSR_ADDR_FLT_MASK, 8'h00);
		rdChk(`CSR_ADDR_INT_FLAG, 8'h00);
		rdChk(`CSR_ADDR_FLT_FLAG, 8'h00);
		wr(`CSR_ADDR_CTRL2, 8'hff);
		rdChk(`CSR_ADDR_CTRL2, 8'h3b);
		check1(1'b1, ctrlOut.chargeEnable);
		wr(`CSR_ADDR_CTRL2, 8'h00);
		check1(1'b0, ctrlOut.chargeEnable);
		check8(8'h00, {6'h00, ctrlOut.thermThreshold});
		check8(8'h00, {6'h00, ctrlOut.lowBattThreshold});
		host_u.access(1'b0, 4'h0, 8'h00, ackV, dataV);
		check1(1'b0, ackV);
		check8(8'h00, dataV);
		// live conditions and their event flags
		@(negedge clk_sys);
		statusIn.powerGood = 1'b1;
		statusIn.inCurReg = 1'b1;
		statusIn.inVoltReg = 1'b1;
		statusIn.thermReg = 1'b1;
		statusIn.chargeState = 3'h3;
		settle();
		check1(1'b1, ctrlOut.irqPulse);
		rdChk(`CSR_ADDR_INT_STAT, 8'hf3);
		rdChk(`CSR_ADDR_INT_FLAG, 8'hf1);
		rdChk(`CSR_ADDR_INT_FLAG, 8'h00);
		@(negedge clk_sys);
		statusIn.powerGood = 1'b0;
		statusIn.inCurReg = 1'b0;
		statusIn.chargeState = 3'h4;
		settle();
		rdChk(`CSR_ADDR_INT_FLAG, 8'h81);
		rdChk(`CSR_ADDR_INT_STAT, 8'h34);
		@(negedge clk_sys);
		statusIn.ovIn = 1'b1;
		statusIn.tShut = 1'b1;
		statusIn.batOv = 1'b1;
		statusIn.flyCap = 1'b1;
		statusIn.capPre = 1'b1;
		settle();
		rdChk(`CSR_ADDR_FLT_STAT, 8'hf4);
		rdChk(`CSR_ADDR_FLT_FLAG, 8'hf4);
		rdChk(`CSR_ADDR_FLT_FLAG, 8'h00);
		// failed source qualification attempts
		for (i = 0; i < 7; i++) begin
			if (i == 6) begin
				rdChk(`CSR_ADDR_FLT_STAT, 8'hf4);
			end
			@(negedge clk_sys);
			statusIn.srcQualDone = 1'b1;
			repeat (3) @(negedge clk_sys);
			statusIn.srcQualDone = 1'b0;
			repeat (3) @(negedge clk_sys);
		end
		settle();
		rdChk(`CSR_ADDR_FLT_STAT, 8'hf6);
		rdChk(`CSR_ADDR_FLT_FLAG, 8'h02);
		wr(`CSR_ADDR_INT_MASK, 8'hff);
		rdChk(`CSR_ADDR_INT_MASK, 8'hfd);
		wr(`CSR_ADDR_FLT_MASK, 8'hff);
		rdChk(`CSR_ADDR_FLT_MASK, 8'hfe);
		for (i = 0; i < 3000 && ctrlOut.irqPulse !== 1'b0; i++) @(negedge clk_sys);
		check1(1'b0, ctrlOut.irqPulse);
		@(negedge clk_sys);
		statusIn.termination = 1'b1;
		watchIrq(20);
		check1(1'b0, seenIrq);
		// watchdog expiry and recovery by the host
		wr(`CSR_ADDR_CTRL2, 8'h09);
		wr(`CSR_ADDR_CTRL1, 8'h99);
		for (i = 0; i < 100 && ctrlOut.wdExpired !== 1'b1; i++) @(negedge clk_sys);
		check1(1'b1, ctrlOut.wdExpired);
		check1(1'b0, ctrlOut.chargeEnable);
		check8(8'h01, {6'h00, ctrlOut.lowBattThreshold});
		rdChk(`CSR_ADDR_CTRL2, 8'h31);
		rdChk(`CSR_ADDR_INT_STAT, 8'h3c);
		rdChk(`CSR_ADDR_INT_FLAG, 8'h0c);
		rdChk(`CSR_ADDR_FLT_STAT, 8'h06);
		wr(`CSR_ADDR_CTRL2, 8'h08);
		check1(1'b0, ctrlOut.chargeEnable);
		wr(`CSR_ADDR_CTRL1, 8'hd9);
		rdChk(`CSR_ADDR_CTRL1, 8'h99);
		check1(1'b0, ctrlOut.wdExpired);
		rdChk(`CSR_ADDR_FLT_STAT, 8'hf6);
		wr(`CSR_ADDR_CTRL1, 8'h09);
		wr(`CSR_ADDR_CTRL2, 8'h08);
		check1(1'b1, ctrlOut.chargeEnable);
		// 5 h at half rate while regulating: 36000 ticks of one cycle
		repeat (35800) @(negedge clk_sys);
		check1(1'b0, ctrlOut.safetyExpired);
		for (i = 0; i < 600 && ctrlOut.safetyExpired !== 1'b1; i++) @(negedge clk_sys);
		check1(1'b1, ctrlOut.safetyExpired);
		watchIrq(10);
		check1(1'b0, seenIrq);
		host_u.access(1'b0, `CSR_ADDR_FLT_FLAG, 8'h00, ackV, dataV);
		check8(8'h08, dataV & 8'h08);
		// software register reset
		wr(`CSR_ADDR_PART, 8'h80);
		rdChk(`CSR_ADDR_CTRL2, 8'h33);
		rdChk(`CSR_ADDR_CTRL1, 8'h9d);
		rdChk(`CSR_ADDR_INT_MASK, 8'h00);
		check1(1'b0, ctrlOut.safetyExpired);
		rdChk(`CSR_ADDR_PART, 8'h29);
		check1(1'b1, ctrlOut.termEnable);
		// event lands in the same cycle as the clearing read
		@(negedge clk_sys);
		statusIn.inCurReg = 1'b1;
		@(negedge clk_sys);
		rdChk(`CSR_ADDR_INT_FLAG, 8'h00);
		rdChk(`CSR_ADDR_INT_FLAG, 8'h40);
		finish_test();
	end
endmodule : tb_top
